// File: rtl/drive_profile_pkg.sv
// package: object indices, user register numbers, defaults and carrier types
package drive_profile_pkg;

  // ---------------------------------------------------------------
  // object indices
  // ---------------------------------------------------------------
  localparam logic [15:0] OBJ_ABORT_CONN   = 16'h6007;
  localparam logic [15:0] OBJ_RECENT_ERR   = 16'h603F;
  localparam logic [15:0] OBJ_CONTROL      = 16'h6040;
  localparam logic [15:0] OBJ_STATUS       = 16'h6041;
  localparam logic [15:0] OBJ_QSTOP        = 16'h605A;
  localparam logic [15:0] OBJ_SHUTDOWN     = 16'h605B;
  localparam logic [15:0] OBJ_DISABLE      = 16'h605C;
  localparam logic [15:0] OBJ_HALT         = 16'h605D;
  localparam logic [15:0] OBJ_FAULT        = 16'h605E;
  localparam logic [15:0] OBJ_MODE_SEL     = 16'h6060;
  localparam logic [15:0] OBJ_MODE_DISP    = 16'h6061;
  localparam logic [15:0] OBJ_POS_DEMAND   = 16'h6062;
  localparam logic [15:0] OBJ_POS_ACTUAL   = 16'h6063;
  localparam logic [15:0] OBJ_POS_ALIAS    = 16'h6064;
  localparam logic [15:0] OBJ_TARGET_POS   = 16'h607A;
  localparam logic [15:0] OBJ_HOME_OFFSET  = 16'h607C;
  localparam logic [15:0] OBJ_ERR_HISTORY  = 16'h1003;

  // ---------------------------------------------------------------
  // internal user register numbers
  // ---------------------------------------------------------------
  localparam logic [7:0] UREG_POS_DEMAND   = 8'h00;
  localparam logic [7:0] UREG_POS_ACTUAL   = 8'h01;
  localparam logic [7:0] UREG_HOME_OFFSET  = 8'h64;
  localparam logic [7:0] UREG_MODE_SEL     = 8'h6B;
  localparam logic [7:0] UREG_MODE_DISP    = 8'h6C;
  localparam logic [7:0] UREG_QSTOP        = 8'h6D;
  localparam logic [7:0] UREG_SHUTDOWN     = 8'h6E;
  localparam logic [7:0] UREG_DISABLE      = 8'h6F;
  localparam logic [7:0] UREG_HALT         = 8'h70;
  localparam logic [7:0] UREG_FAULT        = 8'h71;
  localparam logic [7:0] UREG_CONTROL      = 8'h78;
  localparam logic [7:0] UREG_STATUS       = 8'h79;
  localparam logic [7:0] UREG_TARGET_POS   = 8'h7C;
  localparam logic [7:0] UREG_ABORT_CONN   = 8'h7E;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_ABORT_CONN   = 16'h0000;
  localparam logic [15:0] RST_QSTOP        = 16'h0002;
  localparam logic [15:0] RST_SHUTDOWN     = 16'h0001;
  localparam logic [15:0] RST_DISABLE      = 16'h0001;
  localparam logic [15:0] RST_HALT         = 16'h0001;
  localparam logic [15:0] RST_FAULT        = 16'h0000;
  localparam logic [15:0] RST_CONTROL      = 16'h0000;
  localparam logic [15:0] RST_STATUS       = 16'h0000;
  localparam logic [7:0]  RST_MODE_SEL     = 8'h01;
  localparam logic [7:0]  RST_MODE_DISP    = 8'h01;
  localparam logic [31:0] RST_WORD32       = 32'h0000_0000;
  localparam logic [15:0] RST_ERROR        = 16'h0000;
  localparam logic [15:0] ABORT_CODE_MAX   = 16'h0003;
  localparam logic [15:0] QSTOP_CODE_MIN   = 16'h0001;
  localparam logic [15:0] QSTOP_CODE_MAX   = 16'h0008;
  localparam logic [15:0] OPT_CODE_MAX     = 16'h0001;
  localparam logic [15:0] HALT_CODE_MIN    = 16'h0001;
  localparam logic [15:0] REACT_CODE_MAX   = 16'h0004;
  localparam int          HALT_BIT         = 8;
  localparam int          ABSOLUTE_RELATIVE_SELECT_BIT      = 6;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } obj_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] data;
  } obj_rsp_s;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  num;
    logic [31:0] data;
  } ureg_req_s;

  typedef enum logic [2:0] {
    ACC_OK    = 3'b001,
    ACC_RO    = 3'b010,
    ACC_NOOBJ = 3'b100
  } acc_e;

endpackage

// File: rtl/drive_profile_object_bank.sv
// drive profile object bank: dictionary objects mirrored into user registers
//
// What this block does
// R1: abort reaction code 0..3, RW, default 0
// R2: abort reaction mirrored into user register 126
// R3: recent error shows low 16 history bits
// R4: error persists; cleared by history sub0 zero
// R5: control word mirrored into user register 120
// R6: status word read from user register 121
// R7: quick-stop reaction accepts codes 1 to 8
// R8: quick-stop in register 109, default 2
// R9: shutdown reaction in register 110, default 1
// R10: disable reaction in register 111, default 1
// R11: halt reaction register 112, applies on bit8
// R12: fault reaction mirrored into register 113
// R13: mode select in register 107 low byte
// R14: mode display from register 108, default 1
// R15: demand = user reg 0, actual = 1
// R16: second actual object aliases the first
// R17: target position in 124, absolute_relative_select bit
// R18: home offset in register 100, default 0
// R19: network writes to read-only objects refused
`timescale 1ns/1ns
module drive_profile_object_bank
  import drive_profile_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  input  wire obj_req_s    NET_REQ_I,
  output obj_rsp_s         NET_RSP_O,
  input  wire ureg_req_s   USR_REQ_I,
  output obj_rsp_s         USR_RSP_O,
  input  wire logic        ERR_PUSH_I,
  input  wire logic [31:0] ERR_CODE_I,
  output logic             HALT_ACTIVE_O,
  output logic             ABSOLUTE_RELATIVE_SELECT_O
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] abort_r;
  logic [15:0] qstop_r;
  logic [15:0] shutdown_r;
  logic [15:0] disable_r;
  logic [15:0] halt_r;
  logic [15:0] fault_r;
  logic [15:0] control_r;
  logic [15:0] status_r;
  logic [7:0]  mode_sel_r;
  logic [7:0]  mode_disp_r;
  logic [31:0] pos_demand_r;
  logic [31:0] pos_actual_r;
  logic [31:0] target_r;
  logic [31:0] home_off_r;
  logic [31:0] err_hist_r;
  obj_rsp_s    net_rsp_nxt;
  obj_rsp_s    usr_rsp_nxt;
  acc_e        net_acc;
  logic        net_wr;
  logic        usr_wr;
  logic        hist_clr;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // object index to user register number; 8'hFF when not mirrored
  function automatic logic [7:0] obj_to_ureg(input logic [15:0] idx);
    logic [7:0] n;
    n = 8'hFF;
    unique case (idx)
      OBJ_ABORT_CONN:  n = UREG_ABORT_CONN;
      OBJ_CONTROL:     n = UREG_CONTROL;
      OBJ_STATUS:      n = UREG_STATUS;
      OBJ_QSTOP:       n = UREG_QSTOP;
      OBJ_SHUTDOWN:    n = UREG_SHUTDOWN;
      OBJ_DISABLE:     n = UREG_DISABLE;
      OBJ_HALT:        n = UREG_HALT;
      OBJ_FAULT:       n = UREG_FAULT;
      OBJ_MODE_SEL:    n = UREG_MODE_SEL;
      OBJ_MODE_DISP:   n = UREG_MODE_DISP;
      OBJ_POS_DEMAND:  n = UREG_POS_DEMAND;
      OBJ_POS_ACTUAL:  n = UREG_POS_ACTUAL;
      OBJ_POS_ALIAS:   n = UREG_POS_ACTUAL; // R16
      OBJ_TARGET_POS:  n = UREG_TARGET_POS;
      OBJ_HOME_OFFSET: n = UREG_HOME_OFFSET;
      default:         n = 8'hFF;
    endcase
    return n;
  endfunction

  // read value of a user register number
  function automatic logic [31:0] ureg_value(input logic [7:0] num,
                                             input logic [31:0] others[0:0]);
    return others[0];
  endfunction

  logic [31:0] ureg_rd_net;
  logic [31:0] ureg_rd_usr;
  logic [7:0]  net_num;

  always_comb begin
    net_num = obj_to_ureg(NET_REQ_I.index);
  end

  // shared read mux for both ports
  function automatic logic [31:0] read_ureg(
    input logic [7:0]  num,
    input logic [15:0] ab, qs, sd, ds, hl, fl, cw, sw,
    input logic [7:0]  ms, md,
    input logic [31:0] pd, pa, tg, ho);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (num)
      UREG_ABORT_CONN:  v = {16'h0000, ab};
      UREG_QSTOP:       v = {16'h0000, qs};
      UREG_SHUTDOWN:    v = {16'h0000, sd};
      UREG_DISABLE:     v = {16'h0000, ds};
      UREG_HALT:        v = {16'h0000, hl};
      UREG_FAULT:       v = {16'h0000, fl};
      UREG_CONTROL:     v = {16'h0000, cw};
      UREG_STATUS:      v = {16'h0000, sw};
      UREG_MODE_SEL:    v = {24'h00_0000, ms};
      UREG_MODE_DISP:   v = {24'h00_0000, md};
      UREG_POS_DEMAND:  v = pd;
      UREG_POS_ACTUAL:  v = pa;
      UREG_TARGET_POS:  v = tg;
      UREG_HOME_OFFSET: v = ho;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    ureg_rd_net = read_ureg(net_num, abort_r, qstop_r, shutdown_r, disable_r,
                            halt_r, fault_r, control_r, status_r, mode_sel_r,
                            mode_disp_r, pos_demand_r, pos_actual_r, target_r,
                            home_off_r);
    ureg_rd_usr = read_ureg(USR_REQ_I.num, abort_r, qstop_r, shutdown_r,
                            disable_r, halt_r, fault_r, control_r, status_r,
                            mode_sel_r, mode_disp_r, pos_demand_r, pos_actual_r,
                            target_r, home_off_r);
  end

  // ---------------------------------------------------------------
  // network access checking
  // ---------------------------------------------------------------
  always_comb begin
    net_acc = ACC_OK;
    if (NET_REQ_I.index == OBJ_RECENT_ERR || NET_REQ_I.index == OBJ_ERR_HISTORY) begin
      net_acc = (NET_REQ_I.wr && NET_REQ_I.index == OBJ_RECENT_ERR) ? ACC_RO : ACC_OK;
    end else if (net_num == 8'hFF) begin
      net_acc = ACC_NOOBJ;
    end else if (NET_REQ_I.wr && (net_num == UREG_STATUS || net_num == UREG_MODE_DISP ||
                 net_num == UREG_POS_DEMAND || net_num == UREG_POS_ACTUAL)) begin
      net_acc = ACC_RO; // R19
    end else if (NET_REQ_I.wr) begin
      unique case (net_num)
        UREG_ABORT_CONN: if (NET_REQ_I.data[15:0] > ABORT_CODE_MAX) net_acc = ACC_RO; // R1
        UREG_QSTOP: if (NET_REQ_I.data[15:0] < QSTOP_CODE_MIN ||
                        NET_REQ_I.data[15:0] > QSTOP_CODE_MAX) net_acc = ACC_RO; // R7
        UREG_SHUTDOWN, UREG_DISABLE: if (NET_REQ_I.data[15:0] > OPT_CODE_MAX) net_acc = ACC_RO; // R9 R10
        UREG_HALT: if (NET_REQ_I.data[15:0] < HALT_CODE_MIN ||
                       NET_REQ_I.data[15:0] > REACT_CODE_MAX) net_acc = ACC_RO; // R11
        UREG_FAULT: if (NET_REQ_I.data[15:0] > REACT_CODE_MAX) net_acc = ACC_RO; // R12
        default: net_acc = ACC_OK;
      endcase
    end
  end

  assign net_wr   = NET_REQ_I.req && NET_REQ_I.wr && net_acc == ACC_OK &&
                    net_num != 8'hFF;
  assign usr_wr   = USR_REQ_I.req && USR_REQ_I.wr;
  assign hist_clr = NET_REQ_I.req && NET_REQ_I.wr && NET_REQ_I.index == OBJ_ERR_HISTORY &&
                    NET_REQ_I.sub == 8'h00 && NET_REQ_I.data == 32'h0000_0000;

  // ---------------------------------------------------------------
  // mirrored registers; user program write wins on collision
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      abort_r      <= RST_ABORT_CONN; // R1
      qstop_r      <= RST_QSTOP;      // R8
      shutdown_r   <= RST_SHUTDOWN;   // R9
      disable_r    <= RST_DISABLE;    // R10
      halt_r       <= RST_HALT;       // R11
      fault_r      <= RST_FAULT;
      control_r    <= RST_CONTROL;
      status_r     <= RST_STATUS;
      mode_sel_r   <= RST_MODE_SEL;   // R13
      mode_disp_r  <= RST_MODE_DISP;  // R14
      pos_demand_r <= RST_WORD32;
      pos_actual_r <= RST_WORD32;
      target_r     <= RST_WORD32;
      home_off_r   <= RST_WORD32;     // R18
    end else begin
      if (net_wr && !(usr_wr && USR_REQ_I.num == net_num)) begin
        unique case (net_num)
          UREG_ABORT_CONN:  abort_r    <= NET_REQ_I.data[15:0]; // R2
          UREG_QSTOP:       qstop_r    <= NET_REQ_I.data[15:0]; // R8
          UREG_SHUTDOWN:    shutdown_r <= NET_REQ_I.data[15:0]; // R9
          UREG_DISABLE:     disable_r  <= NET_REQ_I.data[15:0]; // R10
          UREG_HALT:        halt_r     <= NET_REQ_I.data[15:0]; // R11
          UREG_FAULT:       fault_r    <= NET_REQ_I.data[15:0]; // R12
          UREG_CONTROL:     control_r  <= NET_REQ_I.data[15:0]; // R5
          UREG_MODE_SEL:    mode_sel_r <= NET_REQ_I.data[7:0];  // R13
          UREG_TARGET_POS:  target_r   <= NET_REQ_I.data;       // R17
          UREG_HOME_OFFSET: home_off_r <= NET_REQ_I.data;       // R18
          default:          ;
        endcase
      end
      if (usr_wr) begin
        unique case (USR_REQ_I.num)
          UREG_ABORT_CONN:  abort_r      <= USR_REQ_I.data[15:0]; // R2
          UREG_QSTOP:       qstop_r      <= USR_REQ_I.data[15:0]; // R8
          UREG_SHUTDOWN:    shutdown_r   <= USR_REQ_I.data[15:0];
          UREG_DISABLE:     disable_r    <= USR_REQ_I.data[15:0];
          UREG_HALT:        halt_r       <= USR_REQ_I.data[15:0];
          UREG_FAULT:       fault_r      <= USR_REQ_I.data[15:0];
          UREG_CONTROL:     control_r    <= USR_REQ_I.data[15:0]; // R5
          UREG_STATUS:      status_r     <= USR_REQ_I.data[15:0]; // R6
          UREG_MODE_SEL:    mode_sel_r   <= USR_REQ_I.data[7:0];
          UREG_MODE_DISP:   mode_disp_r  <= USR_REQ_I.data[7:0];  // R14
          UREG_POS_DEMAND:  pos_demand_r <= USR_REQ_I.data;       // R15
          UREG_POS_ACTUAL:  pos_actual_r <= USR_REQ_I.data;       // R15
          UREG_TARGET_POS:  target_r     <= USR_REQ_I.data;
          UREG_HOME_OFFSET: home_off_r   <= USR_REQ_I.data;
          default:          ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // error history first entry; a new error wins over the clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      err_hist_r <= RST_WORD32;
    end else if (ERR_PUSH_I) begin
      err_hist_r <= ERR_CODE_I;
    end else if (hist_clr) begin
      err_hist_r <= RST_WORD32; // R4
    end
  end

  // ---------------------------------------------------------------
  // responses, registered, one cycle after the request
  // ---------------------------------------------------------------
  always_comb begin
    net_rsp_nxt      = '0;
    net_rsp_nxt.ack  = NET_REQ_I.req;
    net_rsp_nxt.err  = NET_REQ_I.req && net_acc != ACC_OK; // R19
    if (NET_REQ_I.req && !NET_REQ_I.wr) begin
      if (NET_REQ_I.index == OBJ_RECENT_ERR) begin
        net_rsp_nxt.data = {16'h0000, err_hist_r[15:0]}; // R3
      end else if (NET_REQ_I.index == OBJ_ERR_HISTORY) begin
        net_rsp_nxt.data = err_hist_r;
      end else begin
        net_rsp_nxt.data = ureg_rd_net;
      end
    end
    usr_rsp_nxt      = '0;
    usr_rsp_nxt.ack  = USR_REQ_I.req;
    usr_rsp_nxt.data = (USR_REQ_I.req && !USR_REQ_I.wr) ? ureg_rd_usr : 32'h0000_0000;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      NET_RSP_O <= '0;
      USR_RSP_O <= '0;
    end else begin
      NET_RSP_O <= net_rsp_nxt;
      USR_RSP_O <= usr_rsp_nxt;
    end
  end

  assign HALT_ACTIVE_O              = control_r[HALT_BIT];    // R11
  assign ABSOLUTE_RELATIVE_SELECT_O = control_r[ABSOLUTE_RELATIVE_SELECT_BIT]; // R17

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  sequence ro_write_s;
    NET_REQ_I.req && NET_REQ_I.wr && NET_REQ_I.index == OBJ_STATUS && !usr_wr;
  endsequence

  ro_refused_a: assert property (ro_write_s |=> NET_RSP_O.err && $stable(status_r)) // R19
    else $error("write to read-only object not refused");
  abort_range_a: assert property (NET_REQ_I.req && NET_REQ_I.wr && net_num == UREG_ABORT_CONN &&
                                  NET_REQ_I.data[15:0] > ABORT_CODE_MAX && !usr_wr
                                  |=> NET_RSP_O.err && $stable(abort_r)) // R1
    else $error("network abort code above 3 accepted");
  abort_mirror_a: assert property (net_wr && net_num == UREG_ABORT_CONN && !usr_wr
                                   |=> abort_r == $past(NET_REQ_I.data[15:0])) // R2
    else $error("abort reaction not mirrored");
  err_view_a: assert property (NET_REQ_I.req && !NET_REQ_I.wr &&
                               NET_REQ_I.index == OBJ_RECENT_ERR
                               |=> NET_RSP_O.data[15:0] == $past(err_hist_r[15:0])) // R3
    else $error("recent error view wrong");
  err_hold_a: assert property (!ERR_PUSH_I && !hist_clr |=> $stable(err_hist_r)) // R4
    else $error("error code changed without cause");
  ctrl_mirror_a: assert property (USR_REQ_I.req && !USR_REQ_I.wr && USR_REQ_I.num == UREG_CONTROL
                                  |=> USR_RSP_O.data[15:0] == $past(control_r)) // R5
    else $error("control word mirror wrong");
  alias_a: assert property (NET_REQ_I.req && !NET_REQ_I.wr && NET_REQ_I.index == OBJ_POS_ALIAS
                            |=> NET_RSP_O.data == $past(pos_actual_r)) // R16
    else $error("actual position alias differs");
  halt_out_a: assert property (net_wr && net_num == UREG_CONTROL && !usr_wr
                               |=> HALT_ACTIVE_O == $past(NET_REQ_I.data[HALT_BIT])) // R11
    else $error("halt output disagrees with control word");

  sequence net_read_s(logic [15:0] idx);
    NET_REQ_I.req && !NET_REQ_I.wr && NET_REQ_I.index == idx;
  endsequence

  err_push_a: assert property (ERR_PUSH_I |=> err_hist_r == $past(ERR_CODE_I)) // R4
    else $error("new error entry lost");
  err_clear_a: assert property (hist_clr && !ERR_PUSH_I |=> err_hist_r == RST_WORD32) // R4
    else $error("error history not cleared");
  qstop_range_a: assert property (net_num == UREG_QSTOP && NET_REQ_I.req && NET_REQ_I.wr &&
                                  !(NET_REQ_I.data[15:0] inside {[QSTOP_CODE_MIN:QSTOP_CODE_MAX]})
                                  |=> NET_RSP_O.err) // R7
    else $error("quick-stop code outside 1 to 8 accepted");
  status_view_a: assert property (net_read_s(OBJ_STATUS)
                                  |=> NET_RSP_O.data == {16'h0000, $past(status_r)}) // R6
    else $error("status word view wrong");
  disp_ro_a: assert property (NET_REQ_I.req && NET_REQ_I.wr && NET_REQ_I.index == OBJ_MODE_DISP &&
                              !usr_wr |=> NET_RSP_O.err && $stable(mode_disp_r)) // R19
    else $error("mode display write not refused");
  demand_view_a: assert property (net_read_s(OBJ_POS_DEMAND)
                                  |=> NET_RSP_O.data == $past(pos_demand_r)) // R15
    else $error("position demand view wrong");
  target_mirror_a: assert property (net_wr && net_num == UREG_TARGET_POS && !usr_wr
                                    |=> target_r == $past(NET_REQ_I.data)) // R17
    else $error("target position not mirrored");
  home_mirror_a: assert property (net_wr && net_num == UREG_HOME_OFFSET && !usr_wr
                                  |=> home_off_r == $past(NET_REQ_I.data)) // R18
    else $error("home offset not mirrored");

endmodule // drive_profile_object_bank

// File: bench/drive_profile_partner.sv
// user program model: drives the user register port of the object bank
`timescale 1ns/1ns
module drive_profile_partner
  import drive_profile_pkg::*;
(
  input  wire logic     clk_i,
  output ureg_req_s     usr_req_o,
  input  wire obj_rsp_s usr_rsp_i
);
  initial begin
    usr_req_o = '0;
  end

  // ---------------------------------------------------------------
  // one access, held until the answering edge
  // ---------------------------------------------------------------
  task automatic usr_xfer(input logic wr, input logic [7:0] num, input logic [31:0] d,
                          output obj_rsp_s r);
    usr_req_o = '{req: 1'h1, wr: wr, num: num, data: d};
    @(posedge clk_i);
    #10;
    r = usr_rsp_i;
    // idle fields scrambled so stale values cannot pass for a request
    usr_req_o = '{req: 1'h0, wr: ~wr, num: ~num, data: ~d};
    @(posedge clk_i);
    #10;
  endtask

  // ---------------------------------------------------------------
  // program duties
  // ---------------------------------------------------------------
  task automatic startup();
    obj_rsp_s r;
    usr_xfer(1'h1, UREG_QSTOP, 32'h0000_0002, r);
    usr_xfer(1'h1, UREG_MODE_DISP, 32'h0000_0001, r);
  endtask

  task automatic mode_done(input logic [7:0] mode, input logic prev_done);
    obj_rsp_s r;
    if (prev_done) begin
      usr_xfer(1'h1, UREG_MODE_DISP, {24'h0, mode}, r);
    end
  endtask
endmodule // drive_profile_partner

// File: bench/drive_profile_object_bank_bench.sv
// self-checking bench for the drive profile object bank
`timescale 1ns/1ns
module drive_profile_object_bank_bench
  import drive_profile_pkg::*;
();
  logic        CLK_SYS_I;
  logic        SYS_RST_I;
  obj_req_s    net_req;
  obj_rsp_s    net_rsp;
  ureg_req_s   usr_req;
  obj_rsp_s    usr_rsp;
  logic        err_push;
  logic [31:0] err_code;
  logic        halt_act;
  logic        absrel;
  int          n_fail = 0;
  int          total_checks = 0;
  int          k;
  int          c;
  logic        bad;
  logic [15:0] keep;
  logic [15:0] dflt_idx [13] = '{OBJ_ABORT_CONN, OBJ_QSTOP, OBJ_SHUTDOWN, OBJ_DISABLE,
    OBJ_HALT, OBJ_FAULT, OBJ_CONTROL, OBJ_STATUS, OBJ_MODE_SEL, OBJ_MODE_DISP,
    OBJ_TARGET_POS, OBJ_HOME_OFFSET, OBJ_POS_DEMAND};
  logic [31:0] dflt_val [13] = '{32'h0, 32'h2, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0,
    32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
  logic [15:0] rng_idx [6] = '{OBJ_ABORT_CONN, OBJ_QSTOP, OBJ_SHUTDOWN, OBJ_DISABLE,
    OBJ_HALT, OBJ_FAULT};
  logic [7:0]  rng_reg [6] = '{8'h7E, 8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71};
  logic [15:0] rng_lo  [6] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h1, 16'h0};
  logic [15:0] rng_hi  [6] = '{16'h3, 16'h8, 16'h1, 16'h1, 16'h4, 16'h4};
  logic [15:0] rng_def [6] = '{16'h0, 16'h2, 16'h1, 16'h1, 16'h1, 16'h0};

  drive_profile_object_bank uut (
    .CLK_SYS_I                  (CLK_SYS_I),
    .SYS_RST_I                  (SYS_RST_I),
    .NET_REQ_I                  (net_req),
    .NET_RSP_O                  (net_rsp),
    .USR_REQ_I                  (usr_req),
    .USR_RSP_O                  (usr_rsp),
    .ERR_PUSH_I                 (err_push),
    .ERR_CODE_I                 (err_code),
    .HALT_ACTIVE_O              (halt_act),
    .ABSOLUTE_RELATIVE_SELECT_O (absrel)
  );

  drive_profile_partner prog (
    .clk_i     (CLK_SYS_I),
    .usr_req_o (usr_req),
    .usr_rsp_i (usr_rsp)
  );

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic net_xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] d, output obj_rsp_s r);
    net_req = '{req: 1'h1, wr: wr, index: idx, sub: sub, data: d};
    @(posedge CLK_SYS_I);
    #10;
    r = net_rsp;
    net_req = '{req: 1'h0, wr: ~wr, index: ~idx, sub: ~sub, data: ~d};
    @(posedge CLK_SYS_I);
    #10;
  endtask

  task automatic net_wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                        input logic exp_err);
    obj_rsp_s r;
    net_xfer(1'h1, idx, sub, d, r);
    check($sformatf("net write %h ack", idx), 32'h1, {31'h0, r.ack});
    check($sformatf("net write %h err", idx), {31'h0, exp_err}, {31'h0, r.err});
  endtask

  task automatic net_rd(input logic [15:0] idx, input logic [31:0] exp);
    obj_rsp_s r;
    net_xfer(1'h0, idx, 8'h0, 32'h0, r);
    check($sformatf("net read %h ack", idx), 32'h1, {31'h0, r.ack & ~r.err});
    check($sformatf("net read %h data", idx), exp, r.data);
  endtask

  task automatic usr_rd(input logic [7:0] num, input logic [31:0] exp);
    obj_rsp_s r;
    prog.usr_xfer(1'h0, num, 32'h0, r);
    check($sformatf("user read %h ack", num), 32'h1, {31'h0, r.ack & ~r.err});
    check($sformatf("user read %h data", num), exp, r.data);
  endtask

  task automatic usr_wr(input logic [7:0] num, input logic [31:0] d);
    obj_rsp_s r;
    prog.usr_xfer(1'h1, num, d, r);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    CLK_SYS_I = 1'h0;
    forever #50 CLK_SYS_I = ~CLK_SYS_I;
  end

  initial begin
    repeat (5000) @(posedge CLK_SYS_I);
    n_fail++;
    close_out();
  end

  initial begin
    SYS_RST_I = 1'h1;
    net_req   = '0;
    err_push  = 1'h0;
    err_code  = 32'h0;
    repeat (6) @(posedge CLK_SYS_I);
    #10;
    SYS_RST_I = 1'h0;
    prog.startup();
    for (k = 0; k < 13; k++) begin
      net_rd(dflt_idx[k], dflt_val[k]);
    end
    // every code of each option from 0 to one past its top; refusals leave the mirror alone
    for (k = 0; k < 6; k++) begin
      keep = rng_def[k];
      for (c = 0; c <= int'(rng_hi[k]) + 1; c++) begin
        bad = (16'(c) < rng_lo[k]) || (16'(c) > rng_hi[k]);
        net_wr(rng_idx[k], 8'h0, 32'(c), bad);
        keep = bad ? keep : 16'(c);
        usr_rd(rng_reg[k], {16'h0, keep});
      end
    end
    usr_wr(8'h7E, 32'h0000_0003);
    net_rd(OBJ_ABORT_CONN, 32'h0000_0003);
    net_wr(OBJ_CONTROL, 8'h0, 32'h0000_0100, 1'h0);
    usr_rd(8'h78, 32'h0000_0100);
    check("halt active", 32'h1, {31'h0, halt_act});
    check("absolute_relative_select select", 32'h0, {31'h0, absrel});
    net_wr(OBJ_CONTROL, 8'h0, 32'h0000_0040, 1'h0);
    check("halt active", 32'h0, {31'h0, halt_act});
    check("absolute_relative_select select", 32'h1, {31'h0, absrel});
    usr_wr(8'h79, 32'h0000_BEEF);
    net_rd(OBJ_STATUS, 32'h0000_BEEF);
    net_wr(OBJ_STATUS, 8'h0, 32'h0000_1111, 1'h1);
    usr_rd(8'h79, 32'h0000_BEEF);
    net_wr(OBJ_MODE_SEL, 8'h0, 32'h0000_00FF, 1'h0);
    usr_rd(8'h6B, 32'h0000_00FF);
    prog.mode_done(8'h06, 1'h1);
    net_rd(OBJ_MODE_DISP, 32'h0000_0006);
    net_wr(OBJ_MODE_DISP, 8'h0, 32'h0000_0003, 1'h1);
    usr_rd(8'h6C, 32'h0000_0006);
    usr_wr(8'h00, 32'h1234_5678);
    usr_wr(8'h01, 32'h89AB_CDEF);
    net_rd(OBJ_POS_DEMAND, 32'h1234_5678);
    net_rd(OBJ_POS_ACTUAL, 32'h89AB_CDEF);
    net_rd(OBJ_POS_ALIAS, 32'h89AB_CDEF);
    net_wr(OBJ_POS_ALIAS, 8'h0, 32'h0000_0000, 1'h1);
    usr_rd(8'h01, 32'h89AB_CDEF);
    net_wr(OBJ_TARGET_POS, 8'h0, 32'hDEAD_BEEF, 1'h0);
    usr_rd(8'h7C, 32'hDEAD_BEEF);
    net_wr(OBJ_HOME_OFFSET, 8'h0, 32'hFFFF_0001, 1'h0);
    usr_rd(8'h64, 32'hFFFF_0001);
    net_wr(16'h6099, 8'h0, 32'h0000_0001, 1'h1);
    // error entry outlives its cause; only a zero to the history count clears it
    err_push = 1'h1;
    err_code = 32'hCAFE_1234;
    @(posedge CLK_SYS_I);
    #10;
    err_push = 1'h0;
    err_code = 32'h3501_EDCB;
    repeat (5) @(posedge CLK_SYS_I);
    #10;
    net_rd(OBJ_RECENT_ERR, 32'h0000_1234);
    net_wr(OBJ_RECENT_ERR, 8'h0, 32'h0000_0000, 1'h1);
    net_wr(OBJ_ERR_HISTORY, 8'h1, 32'h0000_0000, 1'h0);
    net_wr(OBJ_ERR_HISTORY, 8'h0, 32'h0000_0005, 1'h0);
    net_rd(OBJ_RECENT_ERR, 32'h0000_1234);
    net_wr(OBJ_ERR_HISTORY, 8'h0, 32'h0000_0000, 1'h0);
    net_rd(OBJ_RECENT_ERR, 32'h0000_0000);
    // second reset in mid-run restores the defaults
    SYS_RST_I = 1'h1;
    @(posedge CLK_SYS_I);
    #10;
    SYS_RST_I = 1'h0;
    net_rd(OBJ_QSTOP, 32'h0000_0002);
    net_rd(OBJ_MODE_SEL, 32'h0000_0001);
    close_out();
  end
endmodule // drive_profile_object_bank_bench
